//--- mcis_alu.sv
// Data path: result and flag update of each data instruction
`timescale 1ns/1ns
module mcis_alu (
  input  wire mcis_pkg::mcis_op_t        op,        // Decoded opcode
  input  wire logic [mcis_pkg::DATA_W-1:0] work,    // Work register
  input  wire logic [mcis_pkg::DATA_W-1:0] mem,     // Addressed data byte
  input  wire logic [mcis_pkg::DATA_W-1:0] imm,     // Immediate field
  input  wire logic [2:0]                  bitsel,  // Bit index
  input  wire logic [mcis_pkg::DATA_W-1:0] flags_in, // Present flags
  output logic      [mcis_pkg::DATA_W-1:0] result,  // Result byte
  output logic      [mcis_pkg::DATA_W-1:0] flags_out // Flags after op
);
  import mcis_pkg::*;

  localparam int unsigned MSB = DATA_W - 1;
  logic [DATA_W-1:0] opnd;
  logic [DATA_W:0]   diff;
  logic [NIB_W:0]    half;
  logic              borrow;
  logic              wrap;

  // Borrowing subtract shared by the three subtract forms
  always_comb begin
    opnd   = (op == subtract_borrow_imm_op) ? imm : mem;
    borrow = ~flags_in[FLAG_CARRY];
    diff   = {1'b0, work} - {1'b0, opnd} - {{DATA_W{1'b0}}, borrow};
    half   = {1'b0, work[NIB_W-1:0]} - {1'b0, opnd[NIB_W-1:0]} - {{NIB_W{1'b0}}, borrow};
    wrap   = (work[MSB] ^ opnd[MSB]) & (diff[MSB] ^ work[MSB]);
  end

  // Untouched flags pass through unchanged
  always_comb begin
    result    = mem;
    flags_out = flags_in;
    case (op)
      add_one_op, add_one_to_work_op: begin
        result = mem + BYTE_ONE;
        flags_out[FLAG_NULL] = (result == '0);
      end
      load_work_mem_op: result = mem;
      load_work_imm_op, return_imm_op: result = imm;
      store_work_op: result = work;
      or_mem_op, or_imm_op, or_to_mem_op: begin
        result = work | ((op == or_imm_op) ? imm : mem);
        flags_out[FLAG_NULL] = (result == '0);
      end
      rotate_left_op, rotate_left_work_op: result = {mem[MSB-1:0], mem[MSB]};
      rotate_left_via_carry_op, rotate_left_via_carry_work_op: begin
        result = {mem[MSB-1:0], flags_in[FLAG_CARRY]};
        flags_out[FLAG_CARRY] = mem[MSB];
      end
      rotate_right_op, rotate_right_work_op: result = {mem[0], mem[MSB:1]};
      rotate_right_via_carry_op, rotate_right_via_carry_work_op: begin
        result = {flags_in[FLAG_CARRY], mem[MSB:1]};
        flags_out[FLAG_CARRY] = mem[0];
      end
      subtract_borrow_op, subtract_borrow_imm_op, subtract_borrow_to_mem_op: begin
        result                 = diff[MSB:0];
        flags_out[FLAG_CARRY]  = ~diff[DATA_W];
        flags_out[FLAG_HALF]   = ~half[NIB_W];
        flags_out[FLAG_WRAP]   = wrap;
        flags_out[FLAG_NULL]   = (diff[MSB:0] == '0);
        flags_out[FLAG_SIGN]   = diff[MSB] ^ wrap;
        flags_out[FLAG_MULTI]  = (diff[MSB:0] == '0) & flags_in[FLAG_NULL];
      end
      decrement_skip_null_op, decrement_skip_null_work_op: result = mem - BYTE_ONE;
      fill_ones_op: result = BYTE_ALL;
      bit_set_op: result = mem | (BYTE_ONE << bitsel);
      default: result = mem;
    endcase
  end
endmodule

//--- mcis_core.sv
// Instruction core with program, data and return stack, reached over AHB-Lite
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// Overview of operation
// - Power-down keeps memories, clears watchdog and prescaler, sets powerdown, clears timeout.
// - Increment adds one to memory byte; memory or work destination; null flag only.
// - Jump loads address field into program counter; two cycles; no flags.
// - Moves copy memory to work, immediate to work, work to memory; no flags.
// - No-operation changes nothing and advances to the next instruction.
// - OR work with memory or immediate; work or memory destination; null only.
// - Return pops program counter from stack and resumes there; no flags.
// - Return-with-immediate pops program counter and loads immediate into work.
// - Interrupt return pops program counter and sets global interrupt enable.
// - A pending interrupt is serviced right after interrupt return, before main code.
// - Rotate left, bit 7 into bit 0; memory or work form; no flags.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry.
// - Rotate right, bit 0 into bit 7; memory or work form; no flags.
// - Rotate right through carry; old carry to bit 7, bit 0 to carry.
// - Subtract with borrow: work minus operand minus inverted carry into work; six flags.
// - Memory form of subtract with borrow writes the difference to memory.
// - After subtract with borrow, carry clear when negative, set otherwise.
// - Decrement-and-skip writes memory minus one back; skips next when zero.
// - Work form puts memory minus one in work, skips when zero.
// - Every conditional skip instruction takes two cycles.
// - Whole-byte set writes all ones to the memory byte; no flags.
// - Bit set forces only the selected bit to one; no flags.
module mcis_core (
  input  wire logic                         clock,     // 100 MHz system clock
  input  wire logic                         sys_rst,   // Async reset, active high
  input  wire logic                         hsel,      // Slave select
  input  wire logic [mcis_pkg::BUS_W-1:0]   haddr,     // Byte address
  input  wire logic [1:0]                   htrans,    // Transfer type
  input  wire logic                         hwrite,    // Write when high
  input  wire logic [2:0]                   hsize,     // Transfer size
  input  wire logic [mcis_pkg::BUS_W-1:0]   hwdata,    // Write data
  input  wire logic                         hready,    // Bus ready in
  input  wire logic                         irq_req,   // Interrupt request pin
  output logic      [mcis_pkg::BUS_W-1:0]   hrdata,    // Read data
  output logic                              hreadyout, // Slave ready
  output logic                              hresp,     // Always OKAY
  output logic                              sleeping   // Core in power-down
);
  import mcis_pkg::*;

  // Memories and architectural state
  logic [INSTR_W-1:0]   pmem  [PMEM_DEPTH];
  logic [DATA_W-1:0]    dmem  [DMEM_DEPTH];
  logic [PC_W-1:0]      stack [STACK_DEPTH];
  logic [SP_W-1:0]      sp;
  logic [PC_W-1:0]      pc;
  logic [DATA_W-1:0]    work_register;
  logic [DATA_W-1:0]    flags;
  logic [DATA_W-1:0]    ctrl;
  logic                 global_irq_enable;
  mcis_state_t          state;
  logic [DATA_W-1:0]    watchdog_counter;
  logic [WD_PRE_W-1:0]  prescaler;
  logic                 irq_meta;
  logic                 irq_sync;

  // Bus data phase
  logic                 dp_valid;
  logic                 dp_write;
  logic                 dp_hit;
  logic                 rd_pend;
  logic [ADDR_W-1:0]    dp_addr;
  logic                 accept;
  logic                 bus_we;
  mcis_region_t         dp_region;
  logic [BUS_W-1:0]     rd_val;

  // Decode and control
  logic [INSTR_W-1:0]   instr;
  mcis_op_t             op;
  logic [DATA_W-1:0]    arg;
  logic [DMEM_AW-1:0]   maddr;
  logic [DATA_W-1:0]    mem_val;
  logic [DATA_W-1:0]    alu_res;
  logic [DATA_W-1:0]    alu_flags;
  logic [SP_W-1:0]      sp_top;
  logic                 exec;
  logic                 take_irq;
  logic                 work_we;
  logic                 mem_we;
  logic                 flags_we;
  logic                 do_pop;
  logic                 to_dummy;
  logic                 go_sleep;
  logic                 wd_tick;
  logic                 wd_trip;
  logic [PC_W-1:0]      next_pc;

  // Address decode, shared by write strobes and read mux
  function automatic mcis_region_t region(input logic [ADDR_W-1:0] a);
    region = rg_none;
    if (a[ADDR_W-1:WIN_LSB] == WIN_PMEM && a[IDX_LSB-1:0] == '0) begin
      region = rg_pmem;
    end else if (a[ADDR_W-1:WIN_LSB] == WIN_DMEM && a[IDX_LSB-1:0] == '0) begin
      region = rg_dmem;
    end else if (a[ADDR_W-1:WIN_LSB] == WIN_REGS) begin
      case (a[WIN_LSB-1:0])
        REG_CTRL:   region = rg_ctrl;
        REG_STATUS: region = rg_status;
        REG_WORK:   region = rg_work;
        REG_FLAGS:  region = rg_flags;
        default:    region = rg_none;
      endcase
    end
  endfunction

  // Fetch straight from program memory; operand byte doubles as address
  assign instr   = pmem[pc];
  assign op      = mcis_op_t'(instr[OP_HI:OP_LO]);
  assign arg     = instr[ARG_HI:ARG_LO];
  assign maddr   = arg[DMEM_AW-1:0];
  assign mem_val = dmem[maddr];
  assign sp_top  = sp - SP_W'(1);

  mcis_alu u_alu (
    .op        (op),
    .work      (work_register),
    .mem       (mem_val),
    .imm       (arg),
    .bitsel    (instr[BIT_HI:BIT_LO]),
    .flags_in  (flags),
    .result    (alu_res),
    .flags_out (alu_flags)
  );

  // Per-instruction strobes; an interrupt at the boundary pre-empts the instruction
  always_comb begin
    exec     = (state == st_exec);
    take_irq = exec && irq_sync && global_irq_enable;
    work_we  = 1'b0;
    mem_we   = 1'b0;
    flags_we = 1'b0;
    do_pop   = 1'b0;
    to_dummy = 1'b0;
    go_sleep = 1'b0;
    next_pc  = pc + PC_ONE;
    if (exec && !take_irq) begin
      case (op)
        powerdown_op: go_sleep = 1'b1;
        add_one_op: begin
          mem_we   = 1'b1;
          flags_we = 1'b1;
        end
        add_one_to_work_op: begin
          work_we  = 1'b1;
          flags_we = 1'b1;
        end
        goto_op: begin
          next_pc  = arg[PC_W-1:0];
          to_dummy = 1'b1;
        end
        load_work_mem_op, load_work_imm_op: work_we = 1'b1;
        store_work_op: mem_we = 1'b1;
        or_mem_op, or_imm_op: begin
          work_we  = 1'b1;
          flags_we = 1'b1;
        end
        or_to_mem_op: begin
          mem_we   = 1'b1;
          flags_we = 1'b1;
        end
        return_op, return_imm_op, irq_return_op: begin
          do_pop   = 1'b1;
          next_pc  = stack[sp_top[1:0]];
          to_dummy = 1'b1;
          work_we  = (op == return_imm_op);
        end
        rotate_left_op, rotate_right_op, fill_ones_op, bit_set_op: begin
          mem_we = 1'b1;
        end
        rotate_left_work_op, rotate_right_work_op: work_we = 1'b1;
        rotate_left_via_carry_op, rotate_right_via_carry_op: begin
          mem_we   = 1'b1;
          flags_we = 1'b1;
        end
        rotate_left_via_carry_work_op, rotate_right_via_carry_work_op,
        subtract_borrow_op, subtract_borrow_imm_op: begin
          work_we  = 1'b1;
          flags_we = 1'b1;
        end
        subtract_borrow_to_mem_op: begin
          mem_we   = 1'b1;
          flags_we = 1'b1;
        end
        decrement_skip_null_op, decrement_skip_null_work_op: begin
          mem_we   = (op == decrement_skip_null_op);
          work_we  = (op == decrement_skip_null_work_op);
          to_dummy = 1'b1;
          // Stepping over the next word squashes it outright
          if (alu_res == '0) begin
            next_pc = pc + PC_TWO;
          end
        end
        default: next_pc = pc + PC_ONE;
      endcase
    end
  end

  // Interrupt pin comes from outside: two-stage synchroniser
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      irq_meta <= irq_req;
      irq_sync <= irq_meta;
    end
  end

  // Sequencer: dummy cycle after jumps, returns, skips and interrupt entry
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= st_idle;
      sleeping <= 1'b0;
    end else if (!ctrl[CTRL_RUN]) begin
      state    <= st_idle;
      sleeping <= 1'b0;
    end else begin
      case (state)
        st_idle: state <= st_exec;
        st_exec: begin
          if (take_irq || to_dummy) begin
            state <= st_dummy;
          end else if (go_sleep) begin
            state    <= st_sleep;
            sleeping <= 1'b1;
          end
        end
        st_dummy: state <= st_exec;
        st_sleep: begin
          // Any request wakes the core, enabled or not
          if (irq_sync) begin
            state    <= st_exec;
            sleeping <= 1'b0;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Program counter; idle holds it at the start so a run begins from zero
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= PC_RST;
    end else if (state == st_idle || wd_trip) begin
      pc <= PC_RST;
    end else if (take_irq) begin
      pc <= IRQ_VECTOR;
    end else if (exec) begin
      pc <= next_pc;
    end
  end

  // Return stack: interrupt entry pushes, returns pop; full stack drops the push
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sp <= '0;
    end else if (take_irq && sp != SP_W'(STACK_DEPTH)) begin
      stack[sp[1:0]] <= pc;
      sp             <= sp + SP_W'(1);
    end else if (do_pop && sp != '0) begin
      sp <= sp_top;
    end
  end

  // Global interrupt enable: cleared on entry, set by interrupt return
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      global_irq_enable <= 1'b0;
    end else if (take_irq) begin
      global_irq_enable <= 1'b0;
    end else if (exec && op == irq_return_op) begin
      global_irq_enable <= 1'b1;
    end else if (bus_we && dp_region == rg_ctrl) begin
      global_irq_enable <= hwdata[CTRL_IRQ_EN];
    end
  end

  // Work register; the core wins over a bus write in the same cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      work_register <= '0;
    end else if (work_we) begin
      work_register <= alu_res;
    end else if (bus_we && dp_region == rg_work) begin
      work_register <= hwdata[DATA_W-1:0];
    end
  end

  // Flags; a watchdog timeout is applied last so it is never lost
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= FLAGS_RST;
    end else begin
      if (flags_we) begin
        flags <= alu_flags;
      end else if (go_sleep) begin
        flags[FLAG_PD]  <= 1'b1;
        flags[FLAG_TMO] <= 1'b0;
      end else if (bus_we && dp_region == rg_flags) begin
        flags <= hwdata[DATA_W-1:0];
      end
      if (wd_trip) begin
        flags[FLAG_TMO] <= 1'b1;
      end
    end
  end

  // Data memory: power-down leaves it untouched
  always_ff @(posedge clock) begin
    if (mem_we) begin
      dmem[maddr] <= alu_res;
    end else if (bus_we && dp_region == rg_dmem) begin
      dmem[dp_addr[IDX_LSB +: DMEM_AW]] <= hwdata[DATA_W-1:0];
    end
  end

  // Program memory is loaded by software only
  always_ff @(posedge clock) begin
    if (bus_we && dp_region == rg_pmem) begin
      pmem[dp_addr[IDX_LSB +: PC_W]] <= hwdata[INSTR_W-1:0];
    end
  end

  // Watchdog: prescaler gives a tick enable; stops while idle or asleep
  assign wd_tick = (prescaler == WD_PRE_LAST);
  assign wd_trip = wd_tick && (watchdog_counter == WD_LIMIT) && ctrl[CTRL_WD_EN];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end else if (go_sleep || wd_trip || !ctrl[CTRL_WD_EN]) begin
      prescaler        <= '0;
      watchdog_counter <= '0;
    end else if (state == st_exec || state == st_dummy) begin
      prescaler <= wd_tick ? '0 : prescaler + WD_PRE_W'(1);
      if (wd_tick) begin
        watchdog_counter <= watchdog_counter + BYTE_ONE;
      end
    end
  end

  // Control register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RST;
    end else if (bus_we && dp_region == rg_ctrl) begin
      ctrl[CTRL_RUN]    <= hwdata[CTRL_RUN];
      ctrl[CTRL_WD_EN]  <= hwdata[CTRL_WD_EN];
    end
  end

  // Bus address phase capture; reads add one wait state so data is registered
  assign accept    = hsel && htrans[1] && hready;
  assign bus_we    = dp_valid && dp_write && dp_hit;
  assign dp_region = region(dp_addr);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dp_valid  <= 1'b0;
      dp_write  <= 1'b0;
      dp_hit    <= 1'b0;
      dp_addr   <= '0;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_valid  <= accept;
      rd_pend   <= accept && !hwrite;
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
      if (accept) begin
        dp_write <= hwrite;
        dp_addr  <= haddr[ADDR_W-1:0];
        dp_hit   <= (haddr[BUS_W-1:ADDR_W] == '0) && (hsize == SIZE_WORD);
      end
    end
  end

  // Read mux; unmapped addresses and wrong sizes read as zero
  always_comb begin
    rd_val = '0;
    case (dp_region)
      rg_ctrl: begin
        rd_val[DATA_W-1:0] = ctrl;
        rd_val[CTRL_IRQ_EN] = global_irq_enable;
      end
      rg_status: begin
        rd_val[PC_W-1:0]             = pc;
        rd_val[STAT_SP_LSB +: SP_W]  = sp;
        rd_val[STAT_ST_LSB +: ST_W]  = state;
        rd_val[STAT_IRQ_EN]          = global_irq_enable;
        rd_val[STAT_SLEEP]           = sleeping;
      end
      rg_work:  rd_val[DATA_W-1:0]  = work_register;
      rg_flags: rd_val[DATA_W-1:0]  = flags;
      rg_pmem:  rd_val[INSTR_W-1:0] = pmem[dp_addr[IDX_LSB +: PC_W]];
      rg_dmem:  rd_val[DATA_W-1:0]  = dmem[dp_addr[IDX_LSB +: DMEM_AW]];
      default:  rd_val = '0;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (rd_pend) begin
      hrdata <= dp_hit ? rd_val : '0;
    end
  end
endmodule

//--- mcis_core_sva.sv
// Bus and power-down checks on the core's ports
`timescale 1ns/1ns
module mcis_core_sva (
  input wire logic        clock, sys_rst, hsel, hwrite, hready, irq_req,
  input wire logic        hreadyout, hresp, sleeping,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Taken address phases
  sequence rd_taken; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence wr_taken; hsel && htrans[1] && hready && hwrite; endsequence
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  read_wait_a: assert property (rd_taken |=> !hreadyout ##1 hreadyout) else $error("read wait");
  write_nowait_a: assert property (wr_taken |=> hreadyout) else $error("write stalled");
  wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
  low_cause_a: assert property (!hreadyout |-> $past(hsel && htrans[1] && hready && !hwrite))
    else $error("wait without read");
  // Read data stands until the next read completes
  rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("hrdata moved");
  unmapped_zero_a: assert property ((rd_taken ##0 haddr[31:12] != 20'h0) |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  sleep_wake_a: assert property ((sleeping ##0 irq_req [*3]) |-> ##[0:2] !sleeping)
    else $error("no wake");
endmodule
bind mcis_core mcis_core_sva chk_i (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .irq_req(irq_req), .hreadyout(hreadyout), .hresp(hresp),
  .sleeping(sleeping), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans),
  .hsize(hsize));

//--- mcis_irq_src.sv
// Interrupt source standing outside the core
`timescale 1ns/1ns
module mcis_irq_src (
  input  wire logic clock,   // System clock
  input  wire logic fire,    // Bench command
  output logic      irq_req  // Request level to core
);
  // Registered so the level never changes mid-cycle
  always_ff @(posedge clock) begin
    irq_req <= fire;
  end
endmodule

//--- mcis_pkg.sv
// Shared constants, opcode set and state types of the instruction core
package mcis_pkg;
  // Widths and depths
  localparam int unsigned BUS_W       = 32;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned INSTR_W     = 16;
  localparam int unsigned PC_W        = 6;
  localparam int unsigned DMEM_AW     = 6;
  localparam int unsigned PMEM_DEPTH  = 64;
  localparam int unsigned DMEM_DEPTH  = 64;
  localparam int unsigned STACK_DEPTH = 4;
  localparam int unsigned SP_W        = 3;
  localparam int unsigned ST_W        = 2;
  // Instruction word fields
  localparam int unsigned OP_HI  = 15;
  localparam int unsigned OP_LO  = 11;
  localparam int unsigned BIT_HI = 10;
  localparam int unsigned BIT_LO = 8;
  localparam int unsigned ARG_HI = 7;
  localparam int unsigned ARG_LO = 0;
  // Flag register bit positions
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_HALF  = 1;
  localparam int unsigned FLAG_NULL  = 2;
  localparam int unsigned FLAG_WRAP  = 3;
  localparam int unsigned FLAG_PD    = 4;
  localparam int unsigned FLAG_TMO   = 5;
  localparam int unsigned FLAG_SIGN  = 6;
  localparam int unsigned FLAG_MULTI = 7;
  // Register map: byte offsets inside the 4 KiB block
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WORK   = 8'h08;
  localparam logic [7:0] REG_FLAGS  = 8'h0c;
  localparam logic [3:0] WIN_REGS   = 4'h0;
  localparam logic [3:0] WIN_PMEM   = 4'h1;
  localparam logic [3:0] WIN_DMEM   = 4'h2;
  localparam int unsigned WIN_LSB   = 8;
  localparam int unsigned IDX_LSB   = 2;
  localparam logic [2:0] SIZE_WORD  = 3'h2;
  // Control and status fields
  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned CTRL_WD_EN  = 1;
  localparam int unsigned CTRL_IRQ_EN = 2;
  localparam int unsigned STAT_SP_LSB = 8;
  localparam int unsigned STAT_ST_LSB = 12;
  localparam int unsigned STAT_IRQ_EN = 16;
  localparam int unsigned STAT_SLEEP  = 17;
  // Reset values and fixed data
  localparam logic [DATA_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ALL  = 8'hff;
  localparam logic [PC_W-1:0]   PC_RST    = 6'h00;
  localparam logic [PC_W-1:0]   PC_ONE    = 6'h01;
  localparam logic [PC_W-1:0]   PC_TWO    = 6'h02;
  localparam logic [PC_W-1:0]   IRQ_VECTOR = 6'h04;
  // Watchdog timing: one tick per prescaler period
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WD_TICK_NS    = 2560;
  localparam int unsigned WD_TICK_CYC   = WD_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WD_PRE_W      = 8;
  localparam logic [WD_PRE_W-1:0] WD_PRE_LAST = WD_PRE_W'(WD_TICK_CYC - 1);
  localparam logic [DATA_W-1:0]   WD_LIMIT    = 8'hff;

  typedef enum logic [OP_HI-OP_LO:0] {
    nop_op, powerdown_op, add_one_op, add_one_to_work_op, goto_op,
    load_work_mem_op, load_work_imm_op, store_work_op,
    or_mem_op, or_imm_op, or_to_mem_op, return_op, return_imm_op, irq_return_op,
    rotate_left_op, rotate_left_work_op, rotate_left_via_carry_op,
    rotate_left_via_carry_work_op, rotate_right_op, rotate_right_work_op,
    rotate_right_via_carry_op, rotate_right_via_carry_work_op,
    subtract_borrow_op, subtract_borrow_imm_op, subtract_borrow_to_mem_op,
    decrement_skip_null_op, decrement_skip_null_work_op, fill_ones_op, bit_set_op
  } mcis_op_t;

  typedef enum logic [ST_W-1:0] {st_idle, st_exec, st_dummy, st_sleep} mcis_state_t;
  typedef enum logic [2:0] {rg_ctrl, rg_status, rg_work, rg_flags, rg_pmem, rg_dmem,
                            rg_none} mcis_region_t;
endpackage

//--- test_mcu_core_instruction_semantics.sv
// Self-checking bench: loads a program over the bus, runs it, reads results
`timescale 1ns/1ns
module test_mcu_core_instruction_semantics;
  import mcis_pkg::*;
  logic clock, sys_rst, hwrite, fire, irq_req, hreadyout, hresp, sleeping;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  int          n_fail, compares;
  mcis_irq_src irq_i (.clock(clock), .fire(fire), .irq_req(irq_req));
  mcis_core dut (.clock(clock), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .irq_req(irq_req),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleeping(sleeping));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] ins(mcis_op_t o, logic [7:0] a);
    return {o, 3'h0, a};
  endfunction
  task summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; a stuck bus ends the run
  task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    int k;
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    for (k = 0; k < 20; k++) begin @(posedge clock); if (hreadyout) break; end
    if (k == 20) begin n_fail++; summarize; end
    htrans <= 2'h0; hwdata <= d;
    for (k = 0; k < 20; k++) begin @(posedge clock); if (hreadyout) break; end
    r = hrdata;
    if (k == 20) begin n_fail++; summarize; end
  endtask
  task rd(input string n, input logic [31:0] a, e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  // Stops the core, loads nine words, restarts from zero, waits for power-down
  task run(input logic [15:0] p [9]);
    logic [31:0] r;
    int k;
    xfer(1'b1, 32'h00, 32'h0, r);
    for (k = 0; k < 9; k++) xfer(1'b1, 32'(32'h100 + 4 * k), {16'h0, p[k]}, r);
    xfer(1'b1, 32'h00, 32'h1, r);
    for (k = 0; k < 100 && sleeping !== 1'b1; k++) @(posedge clock);
    chk("sleeping", 32'h1, {31'h0, sleeping});
  endtask
  // Increments, carry rotates, jump over a word, bit set, subtract into memory
  task t_prog2;
    logic [15:0] p [9];
    fire <= 1'b0;
    p = '{ins(add_one_op, 8'h03), ins(add_one_to_work_op, 8'h04),
      ins(rotate_right_via_carry_op, 8'h03), ins(goto_op, 8'h05), ins(fill_ones_op, 8'h01),
      ins(rotate_left_via_carry_work_op, 8'h01), ins(bit_set_op, 8'h02) | 16'h0700,
      ins(subtract_borrow_to_mem_op, 8'h02), ins(powerdown_op, 8'h00)};
    run(p);
    rd("work", 32'h08, 32'h06);
    rd("flags", 32'h0c, 32'h1a);
    rd("jumped", 32'h204, 32'h03);
    rd("borrowed", 32'h208, 32'h85);
    rd("carried", 32'h20c, 32'hab);
    rd("kept", 32'h210, 32'hff);
  endtask
  // Skip squashes a store; sleep ends the run of code
  task t_prog;
    logic [31:0] r;
    int k;
    logic [15:0] p [9];
    logic [7:0]  d [4];
    p = '{ins(load_work_imm_op, 8'h81), ins(rotate_left_op, 8'h01), ins(or_imm_op, 8'h10),
      ins(decrement_skip_null_op, 8'h02), ins(store_work_op, 8'h03), ins(fill_ones_op, 8'h04),
      ins(subtract_borrow_imm_op, 8'h01), ins(powerdown_op, 8'h00), ins(goto_op, 8'h08)};
    d = '{8'h81, 8'h01, 8'h55, 8'h00};
    for (k = 0; k < 4; k++) xfer(1'b1, 32'(32'h204 + 4 * k), {24'h0, d[k]}, r);
    xfer(1'b1, 32'h0c, 32'h0, r);
    run(p);
    rd("work", 32'h08, 32'h8f);
    rd("flags", 32'h0c, 32'h51);
    rd("rotated", 32'h204, 32'h03);
    rd("counted", 32'h208, 32'h00);
    rd("squashed", 32'h20c, 32'h55);
    rd("filled", 32'h210, 32'hff);
    rd("unmapped", 32'h1000, 32'h0);
    fire <= 1'b1;
    for (k = 0; k < 20 && sleeping !== 1'b0; k++) @(posedge clock);
    chk("woken", 32'h0, {31'h0, sleeping});
  endtask
  initial begin
    sys_rst = 1; hwrite = 0; fire = 0; haddr = 0; hwdata = 0; htrans = 0;
    n_fail = 0; compares = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    t_prog;
    t_prog2;
    summarize;
  end
endmodule
